// ### src/twp_defs.vh
// Constants for the timed write protection gates.
// Contract
// - Writing 0xaa then 0x55 to the ticket gate grants one guarded write.
// - The first guarded write consumes the ticket; the next needs the key.
// - Reads of ticket-guarded registers always succeed, locked or not.
// - Ticket gate guards watchdog restart bit at 0xd8, 0xc6 and 0x9d.
// - A granted ticket never times out; it lasts until used or voided.
// - Any access to the ticket gate after a grant voids the ticket.
// - Ticket gate reads lock flag in bit 0: 1 unlocked, 0 locked.
// - Window gate uses the same key and then allows any number of writes.
// - The window stays open 256 clock periods, then relocks by itself.
// - Repeating the key while open extends the window.
// - Writing 0x00 to the window gate closes the window at once.
// - Window gate reads its open flag in bit 0.
// - Gates run on the CPU clock and hold state while it is stopped.
// - The wake-up enable mask register is guarded by the window gate.
`ifndef TWP_DEFS_VH
`define TWP_DEFS_VH
`define TWP_ADDR_TICKET 8'hc7
`define TWP_ADDR_WINDOW 8'hc9
`define TWP_ADDR_WDCTL 8'hd8
`define TWP_ADDR_MEMCFG 8'hc6
`define TWP_ADDR_ADRCFG 8'h9d
`define TWP_ADDR_WAKEMASK 8'h9f
`define TWP_KEY_FIRST 8'haa
`define TWP_KEY_SECOND 8'h55
`define TWP_WINDOW_CLOSE 8'h00
`define TWP_WINDOW_CYCLES 256
`define TWP_EXTEND_CYCLES 128
`define TWP_LOCK_BIT 0
`endif

// ### src/twp_gate.v
// Single-ticket and timed-window write protection gates.
`include "twp_defs.vh"
`default_nettype none
module twp_gate #(
  parameter WINDOW_CYCLES = `TWP_WINDOW_CYCLES,
  parameter EXTEND_CYCLES = `TWP_EXTEND_CYCLES,
  parameter CW = 9
) (
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_addr,
  input wire [7:0] i_sfr_wdata,
  input wire i_wdctl_restart_bit,
  output reg [7:0] o_sfr_rdata,
  output reg o_sfr_rvalid,
  output reg o_single_ticket_lock_flag,
  output reg o_timed_window_lock_flag,
  output reg o_guarded_wr_grant,
  output reg o_guarded_wr_block
);
  // Key recognizer states.
  localparam KEY_IDLE = 1'b0;
  localparam KEY_GOT_FIRST = 1'b1;
  localparam [CW-1:0] WIN_LOAD = WINDOW_CYCLES[CW-1:0];
  localparam [CW:0] EXT_ADD = EXTEND_CYCLES[CW:0];
  localparam [CW:0] WIN_MAX = WINDOW_CYCLES[CW:0];

  reg ticket_key;
  reg window_key;
  reg ticket_open;
  reg [CW-1:0] window_count;
  reg next_ticket_key;
  reg next_window_key;
  reg next_ticket_open;
  reg [CW-1:0] next_window_count;
  reg [CW:0] ext_sum;
  reg ticket_target;
  reg window_target;
  reg [7:0] next_rdata;

  wire acc_ticket = (i_sfr_wr | i_sfr_rd) &&
    (i_sfr_addr == `TWP_ADDR_TICKET);
  wire wr_ticket = i_sfr_wr && (i_sfr_addr == `TWP_ADDR_TICKET);
  wire wr_window = i_sfr_wr && (i_sfr_addr == `TWP_ADDR_WINDOW);
  wire window_open = (window_count != {CW{1'b0}});

  always @* begin
    // The watchdog control register is guarded only when the restart bit
    // is written as one.
    ticket_target = (i_sfr_addr == `TWP_ADDR_MEMCFG) ||
      (i_sfr_addr == `TWP_ADDR_ADRCFG) ||
      ((i_sfr_addr == `TWP_ADDR_WDCTL) && i_wdctl_restart_bit);
    window_target = (i_sfr_addr == `TWP_ADDR_WAKEMASK);
  end

  always @* begin
    next_ticket_key = ticket_key;
    next_ticket_open = ticket_open;
    if (acc_ticket && ticket_open) begin
      next_ticket_open = 1'b0;
      next_ticket_key = KEY_IDLE;
    end else if (wr_ticket) begin
      case (ticket_key)
        KEY_IDLE: begin
          if (i_sfr_wdata == `TWP_KEY_FIRST) begin
            next_ticket_key = KEY_GOT_FIRST;
          end
        end
        KEY_GOT_FIRST: begin
          next_ticket_key = KEY_IDLE;
          if (i_sfr_wdata == `TWP_KEY_SECOND) begin
            next_ticket_open = 1'b1;
          end else if (i_sfr_wdata == `TWP_KEY_FIRST) begin
            next_ticket_key = KEY_GOT_FIRST;
          end
        end
        default: begin
          next_ticket_key = KEY_IDLE;
        end
      endcase
    end else if (i_sfr_wr && ticket_target && ticket_open) begin
      next_ticket_open = 1'b0;
    end else if (i_sfr_wr) begin
      next_ticket_key = KEY_IDLE;
    end
  end

  always @* begin
    next_window_key = window_key;
    next_window_count = window_count;
    ext_sum = {1'b0, window_count} + EXT_ADD;
    if (window_open) begin
      next_window_count = window_count - {{(CW-1){1'b0}}, 1'b1};
    end
    if (wr_window) begin
      if (i_sfr_wdata == `TWP_WINDOW_CLOSE) begin
        next_window_count = {CW{1'b0}};
        next_window_key = KEY_IDLE;
      end else begin
        case (window_key)
          KEY_IDLE: begin
            if (i_sfr_wdata == `TWP_KEY_FIRST) begin
              next_window_key = KEY_GOT_FIRST;
            end
          end
          KEY_GOT_FIRST: begin
            next_window_key = KEY_IDLE;
            if (i_sfr_wdata == `TWP_KEY_SECOND) begin
              if (!window_open) begin
                next_window_count = WIN_LOAD;
              end else if (ext_sum > WIN_MAX) begin
                next_window_count = WIN_LOAD;
              end else begin
                next_window_count = ext_sum[CW-1:0];
              end
            end else if (i_sfr_wdata == `TWP_KEY_FIRST) begin
              next_window_key = KEY_GOT_FIRST;
            end
          end
          default: begin
            next_window_key = KEY_IDLE;
          end
        endcase
      end
    end else if (i_sfr_wr) begin
      next_window_key = KEY_IDLE;
    end
  end

  always @* begin
    next_rdata = 8'h00;
    if (i_sfr_addr == `TWP_ADDR_TICKET) begin
      next_rdata[`TWP_LOCK_BIT] = ticket_open;
    end else if (i_sfr_addr == `TWP_ADDR_WINDOW) begin
      next_rdata[`TWP_LOCK_BIT] = window_open;
    end
  end

  // State advances only on CPU clock edges, so a stopped clock freezes it.
  always @(posedge i_ref_clk) begin
    if (i_rst) begin
      ticket_key <= KEY_IDLE;
      window_key <= KEY_IDLE;
      ticket_open <= 1'b0;
      window_count <= {CW{1'b0}};
      o_sfr_rdata <= 8'h00;
      o_sfr_rvalid <= 1'b0;
      o_single_ticket_lock_flag <= 1'b0;
      o_timed_window_lock_flag <= 1'b0;
      o_guarded_wr_grant <= 1'b0;
      o_guarded_wr_block <= 1'b0;
    end else begin
      ticket_key <= next_ticket_key;
      window_key <= next_window_key;
      ticket_open <= next_ticket_open;
      window_count <= next_window_count;
      o_sfr_rdata <= i_sfr_rd ? next_rdata : 8'h00;
      o_sfr_rvalid <= i_sfr_rd;
      o_single_ticket_lock_flag <= next_ticket_open;
      o_timed_window_lock_flag <= (next_window_count != {CW{1'b0}});
      o_guarded_wr_grant <= i_sfr_wr &&
        ((ticket_target && ticket_open) ||
         (window_target && window_open));
      o_guarded_wr_block <= i_sfr_wr &&
        ((ticket_target && !ticket_open) ||
         (window_target && !window_open));
    end
  end
endmodule
`default_nettype wire

// ### verification/twp_gate_bench.sv
// Self-checking testbench for the timed write protection gates.
`default_nettype none
module twp_gate_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 16;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rb = 1, rv, tk, wn, gr, bl;
  logic [7:0] addr = 0, wdat = 0, rdat;
  logic [7:0] tg [3] = '{8'hc6, 8'h9d, 8'hd8};
  int err_total = 0, comparisons = 0, n;
  twp_gate #(.WINDOW_CYCLES(WIN), .EXTEND_CYCLES(WIN), .CW(5)) DUT (
    .i_ref_clk(clk), .i_rst(rst), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_addr(addr), .i_sfr_wdata(wdat), .i_wdctl_restart_bit(rb),
    .o_sfr_rdata(rdat), .o_sfr_rvalid(rv), .o_single_ticket_lock_flag(tk),
    .o_timed_window_lock_flag(wn), .o_guarded_wr_grant(gr),
    .o_guarded_wr_block(bl));
  initial forever #20 clk = ~clk;
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(logic w, logic r, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdat <= d;
  endtask
  task automatic put(logic w, logic r, logic [7:0] a, logic [7:0] d);
    acc(w, r, a, d);
    acc(0, 0, 0, 0);
    #1;
  endtask
  task automatic key(logic [7:0] a);
    acc(1, 0, a, 8'haa);
    put(1, 0, a, 8'h55);
  endtask
  task automatic wlen(int e);
    n = 0;
    while (wn === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("window length", e[7:0], n[7:0]);
  endtask
  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    put(0, 1, 8'hc9, 0);
    chk("window read", 8'h00, rdat);
    chk("read valid", 1, rv);
    put(0, 1, 8'hc6, 0);
    chk("locked read valid", 1, rv);
    chk("read not blocked", 0, bl);
    key(8'hc7);
    repeat (40) @(posedge clk);
    #1;
    chk("ticket held", 1, tk);
    put(1, 0, 8'hc6, 1);
    chk("grant", 1, gr);
    put(1, 0, 8'hc6, 2);
    chk("block", 1, bl);
    for (int i = 0; i < 3; i++) begin
      key(8'hc7);
      put(1, 0, tg[i], 1);
      chk("target grant", 1, gr);
    end
    rb <= 0;
    put(1, 0, 8'hd8, 0);
    chk("plain watchdog write", 0, {gr, bl});
    rb <= 1;
    key(8'hc7);
    put(0, 1, 8'hc7, 0);
    chk("ticket read", 8'h01, rdat);
    chk("voided", 0, tk);
    acc(1, 0, 8'hc7, 8'haa);
    acc(1, 0, 8'h80, 8'h00);
    put(1, 0, 8'hc7, 8'h55);
    chk("broken key", 0, tk);
    key(8'hc9);
    put(1, 0, 8'h9f, 1);
    chk("window grant", 1, gr);
    put(1, 0, 8'h9f, 2);
    chk("window grant", 1, gr);
    put(0, 1, 8'hc9, 0);
    chk("window read", 8'h01, rdat);
    wlen(WIN - 6);
    key(8'hc9);
    repeat (6) @(posedge clk);
    key(8'hc9);
    wlen(WIN);
    key(8'hc9);
    put(1, 0, 8'hc9, 8'h00);
    chk("closed", 0, wn);
    put(1, 0, 8'h9f, 3);
    chk("window block", 1, bl);
    chk("ticket closed", 0, tk);
    final_report;
  end
endmodule
`default_nettype wire

// ### verification/twp_gate_sva.sv
// Assertion checker for the timed write protection gates.
`default_nettype none
module twp_gate_sva #(parameter WINDOW_CYCLES = 16) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic i_wdctl_restart_bit,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_rvalid,
  input wire logic o_single_ticket_lock_flag,
  input wire logic o_timed_window_lock_flag,
  input wire logic o_guarded_wr_grant,
  input wire logic o_guarded_wr_block
);
  timeunit 1ns;
  timeprecision 1ps;
  wire tk = o_single_ticket_lock_flag;
  wire wn = o_timed_window_lock_flag;
  wire ta = i_sfr_wr && i_sfr_addr == 8'hc7;
  wire w6 = i_sfr_wr && i_sfr_addr == 8'hc6;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  AST_RVALID: assert property (i_sfr_rd |=> o_sfr_rvalid)
    else $error("read not answered");
  AST_TKT_KEY: assert property (!tk && ta && i_sfr_wdata == 8'haa
    ##1 ta && i_sfr_wdata == 8'h55 |=> tk) else $error("key ignored");
  AST_TKT_VOID: assert property (tk && i_sfr_addr == 8'hc7 &&
    (i_sfr_wr || i_sfr_rd) |=> !tk) else $error("ticket not voided");
  AST_TKT_HOLD: assert property (tk && !i_sfr_wr && !i_sfr_rd |=> tk)
    else $error("ticket lost");
  AST_TKT_USE: assert property (tk && w6 |=> o_guarded_wr_grant && !tk)
    else $error("ticket not consumed");
  AST_LOCKED: assert property (!tk && !wn && w6 |=> o_guarded_wr_block
    && !o_guarded_wr_grant) else $error("locked write let through");
  AST_WIN_CLOSE: assert property (i_sfr_wr && i_sfr_wdata == 8'h00 &&
    i_sfr_addr == 8'hc9 |=> !wn) else $error("window not closed");
  AST_WIN_WR: assert property (wn && i_sfr_wr && i_sfr_addr == 8'h9f
    |=> o_guarded_wr_grant) else $error("window write refused");
  AST_WIN_RD: assert property (i_sfr_rd && i_sfr_addr == 8'hc9
    |=> o_sfr_rdata[0] == $past(wn)) else $error("window flag misread");
  // Cycles since the last second-key write to the window gate.
  logic [15:0] since;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || (i_sfr_wr && i_sfr_addr == 8'hc9 &&
        i_sfr_wdata == 8'h55)) begin
      since <= 16'h0000;
    end else if (since != 16'hffff) begin
      since <= since + 16'h0001;
    end
  end
  AST_WIN_EXPIRE: assert property (wn |-> since < WINDOW_CYCLES)
    else $error("window open too long");
  AST_WIN_KEY: assert property (i_sfr_wr && i_sfr_addr == 8'hc9 &&
    i_sfr_wdata == 8'haa ##1 i_sfr_wr && i_sfr_addr == 8'hc9 &&
    i_sfr_wdata == 8'h55 |=> wn) else $error("window key ignored");
  AST_WD_FREE: assert property (i_sfr_wr && i_sfr_addr == 8'hd8 &&
    !i_wdctl_restart_bit |=> !o_guarded_wr_grant && !o_guarded_wr_block)
    else $error("plain watchdog write gated");
endmodule
bind twp_gate twp_gate_sva #(.WINDOW_CYCLES(WINDOW_CYCLES)) u_sva (.*);
`default_nettype wire
